// File: pkg/sps_pkg.sv
/*
  Constants for the special-function-register page selector and page stack.
  Assumes an 8-bit core that issues direct-addressed byte and bit accesses.
*/
package sps_pkg;

  // Window of the special-function-register space
  localparam logic [7:0] SFR_LO          = 8'h80;
  localparam logic [7:0] SFR_HI          = 8'hFF;

  // Low nibbles of the bit-addressable registers
  localparam logic [3:0] BIT_NIB_A       = 4'h0;
  localparam logic [3:0] BIT_NIB_B       = 4'h8;

  // Register offsets
  localparam logic [7:0] OFS_PAGE_SELECT   = 8'hA7;
  localparam logic [7:0] OFS_PAGE_CONTROL  = 8'hBC;
  localparam logic [7:0] OFS_STACK_READOUT = 8'hD7;

  // Pages on which the paged control registers appear
  localparam logic [7:0] PAGE_OF_CONTROL = 8'h10;
  localparam logic [7:0] PAGE_OF_READOUT = 8'h10;

  // Fields of page_control
  localparam int         AUTO_EN_BIT     = 0;
  localparam int         IDX_LSB         = 4;
  localparam int         IDX_W           = 3;

  // Reset values
  localparam logic [7:0] RST_PAGE_SELECT = 8'h00;
  localparam logic [7:0] RST_AUTO_EN     = 8'h01;
  localparam logic [2:0] RST_STACK_INDEX = 3'h0;
  localparam logic [7:0] RST_STACK_ENTRY = 8'h00;

  // Stack geometry
  localparam int         STACK_DEPTH     = 5;
  localparam logic [2:0] IDX_TOP         = 3'h0;
  localparam logic [2:0] IDX_BOTTOM      = 3'h4;

  // Core registers that decode on every page
  localparam int         NUM_CORE        = 14;
  localparam logic [7:0] CORE_ADDRS [NUM_CORE] = '{
    8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h90, 8'hA0,
    8'hA7, 8'hA8, 8'hB0, 8'hB8, 8'hD0, 8'hE0, 8'hF0
  };

  // Page presented to the peripherals for a core register
  localparam logic [7:0] CORE_PAGE       = 8'h00;

  typedef enum logic [1:0] {
    SPS_STK_HOLD = 2'b00,
    SPS_STK_PUSH = 2'b01,
    SPS_STK_POP  = 2'b11
  } sps_stk_op_t;

endpackage

// File: design/sps_stack_cell.sv
/*
  One byte of page state: an entry of the page stack or the page register.
  Assumes the caller computes the next value; this cell only stores it.
*/
`timescale 1ns/1ns
`default_nettype none

module sps_stack_cell (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_load,
  input  wire logic [7:0] i_d,
  output logic      [7:0] o_q
);
  import sps_pkg::*;

  logic [7:0] entry_ff;
  logic [7:0] nxt_entry;

  always_comb begin
    nxt_entry = entry_ff;
    if (i_load) begin
      nxt_entry = i_d;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      entry_ff <= RST_STACK_ENTRY;
    end else begin
      entry_ff <= nxt_entry;
    end
  end

  assign o_q = entry_ff;

endmodule

`default_nettype wire

// File: design/sps_page_stack.sv
/*
  Direct-access decoder for the special-function-register window with
  page selection, a five-entry page stack and stack read-back.
  Assumes one access per cycle from the core, interrupt entry and return
  given as one-cycle pulses at vectoring and at the return instruction,
  and peripherals that answer reads in the same cycle as the request.
*/
`timescale 1ns/1ns
`default_nettype none

module sps_page_stack (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  // Core access
  input  wire logic       i_acc_valid,
  input  wire logic       i_acc_direct,
  input  wire logic       i_acc_bit,
  input  wire logic       i_acc_wr,
  input  wire logic [7:0] i_acc_addr,
  input  wire logic [7:0] i_acc_wdata,
  input  wire logic       i_acc_wbit,
  output logic            o_acc_rvalid,
  output logic      [7:0] o_acc_rdata,
  output logic            o_acc_bit_err,
  // Data memory side
  output logic            o_ram_valid,
  // Interrupt sequencing
  input  wire logic       i_int_entry,
  input  wire logic [7:0] i_int_page,
  input  wire logic       i_int_return,
  // Peripheral register side
  output logic            o_per_valid,
  output logic            o_per_wr,
  output logic            o_per_bit,
  output logic      [2:0] o_per_bit_pos,
  output logic      [7:0] o_per_addr,
  output logic      [7:0] o_per_page,
  output logic      [7:0] o_per_wdata,
  output logic            o_per_wbit,
  input  wire logic [7:0] i_per_rdata,
  // Page state
  output logic      [7:0] o_page_select,
  output logic            o_auto_page_enable
);
  import sps_pkg::*;

  // Address decode
  logic       in_window;
  logic       sfr_acc;
  logic [7:0] byte_addr;
  logic       bit_ok;
  logic       bit_bad;
  logic       is_core;
  logic       hit_select;
  logic       hit_control;
  logic       hit_readout;
  logic       own_hit;

  // Page state
  logic [7:0] entry_q [STACK_DEPTH];
  logic [7:0] entry_d [STACK_DEPTH];
  logic       entry_ld [STACK_DEPTH];
  sps_stk_op_t stk_op;

  logic       auto_en_ff;
  logic       nxt_auto_en;
  logic [2:0] stack_index_ff;
  logic [2:0] nxt_stack_index;

  logic       rvalid_ff;
  logic       nxt_rvalid;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic       bit_err_ff;
  logic       nxt_bit_err;
  logic [7:0] read_byte;
  logic [7:0] readout_val;

  // Bit address above 0x7F names a register byte and a bit in it
  always_comb begin
    byte_addr = i_acc_addr;
    if (i_acc_bit) begin
      byte_addr = {i_acc_addr[7:3], 3'b000};
    end
  end

  // Bit operands at 0x80 and up are always register bits
  assign in_window = (i_acc_addr >= SFR_LO) && (i_acc_addr <= SFR_HI);
  assign sfr_acc   = i_acc_valid && in_window && (i_acc_direct || i_acc_bit);
  assign o_ram_valid = i_acc_valid && !sfr_acc;

  assign bit_ok  = (byte_addr[3:0] == BIT_NIB_A) || (byte_addr[3:0] == BIT_NIB_B);
  assign bit_bad = sfr_acc && i_acc_bit && !bit_ok;

  always_comb begin
    is_core = 1'b0;
    for (int k = 0; k < NUM_CORE; k++) begin
      if (byte_addr == CORE_ADDRS[k]) begin
        is_core = 1'b1;
      end
    end
  end

  assign hit_select  = sfr_acc && !i_acc_bit && (byte_addr == OFS_PAGE_SELECT);
  assign hit_control = sfr_acc && !i_acc_bit && (byte_addr == OFS_PAGE_CONTROL)
                       && (entry_q[0] == PAGE_OF_CONTROL);
  assign hit_readout = sfr_acc && !i_acc_bit && (byte_addr == OFS_STACK_READOUT)
                       && (entry_q[0] == PAGE_OF_READOUT);
  assign own_hit     = hit_select || hit_control || hit_readout;

  // Peripheral strobes carry the page; core registers ignore it
  always_comb begin
    o_per_valid   = sfr_acc && !own_hit && !bit_bad;
    o_per_wr      = i_acc_wr;
    o_per_bit     = i_acc_bit;
    o_per_bit_pos = i_acc_addr[2:0];
    o_per_addr    = byte_addr;
    o_per_wdata   = i_acc_wdata;
    o_per_wbit    = i_acc_wbit;
    o_per_page    = entry_q[0];
    if (is_core) begin
      o_per_page = CORE_PAGE;
    end
  end

  // Stack operation; entry wins over a return in the same cycle
  always_comb begin
    stk_op = SPS_STK_HOLD;
    if (auto_en_ff) begin
      if (i_int_entry) begin
        stk_op = SPS_STK_PUSH;
      end else if (i_int_return) begin
        stk_op = SPS_STK_POP;
      end
    end
  end

  // Next values of the page register (entry 0) and the stack entries
  always_comb begin
    for (int k = 0; k < STACK_DEPTH; k++) begin
      entry_d[k]  = entry_q[k];
      entry_ld[k] = 1'b0;
    end
    case (stk_op)
      SPS_STK_PUSH: begin
        for (int k = STACK_DEPTH - 1; k >= 1; k--) begin
          entry_d[k]  = entry_q[k - 1];
          entry_ld[k] = 1'b1;
        end
        entry_d[0]  = i_int_page;
        entry_ld[0] = 1'b1;
      end
      SPS_STK_POP: begin
        entry_d[0]  = entry_q[1];
        entry_ld[0] = 1'b1;
        for (int k = 1; k < STACK_DEPTH - 1; k++) begin
          entry_d[k]  = entry_q[k + 1];
          entry_ld[k] = 1'b1;
        end
      end
      SPS_STK_HOLD: begin
        if (hit_select && i_acc_wr) begin
          entry_d[0]  = i_acc_wdata;
          entry_ld[0] = 1'b1;
        end
      end
      default: begin
        for (int k = 0; k < STACK_DEPTH; k++) begin
          entry_ld[k] = 1'b0;
        end
      end
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < STACK_DEPTH; g++) begin : g_entry
      sps_stack_cell u_cell (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .i_load (entry_ld[g]),
        .i_d    (entry_d[g]),
        .o_q    (entry_q[g])
      );
    end
  endgenerate

  // Page control register
  always_comb begin
    nxt_auto_en     = auto_en_ff;
    nxt_stack_index = stack_index_ff;
    if (hit_control && i_acc_wr) begin
      nxt_auto_en     = i_acc_wdata[AUTO_EN_BIT];
      nxt_stack_index = i_acc_wdata[IDX_LSB +: IDX_W];
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      auto_en_ff     <= RST_AUTO_EN[0];
      stack_index_ff <= RST_STACK_INDEX;
    end else begin
      auto_en_ff     <= nxt_auto_en;
      stack_index_ff <= nxt_stack_index;
    end
  end

  // Stack readout; index 0 is the page register itself
  always_comb begin
    readout_val = 8'h00;
    if (stack_index_ff <= IDX_BOTTOM) begin
      readout_val = entry_q[stack_index_ff];
    end
  end

  // Read data mux; bad bit addresses read as zero, other misses take peripheral data
  always_comb begin
    read_byte = i_per_rdata;
    if (hit_select) begin
      read_byte = entry_q[0];
    end else if (hit_control) begin
      read_byte = 8'h00;
      read_byte[AUTO_EN_BIT] = auto_en_ff;
      read_byte[IDX_LSB +: IDX_W] = stack_index_ff;
    end else if (hit_readout) begin
      read_byte = readout_val;
    end else if (bit_bad) begin
      read_byte = 8'h00;
    end
  end

  always_comb begin
    nxt_rvalid  = sfr_acc && !i_acc_wr;
    nxt_rdata   = rdata_ff;
    nxt_bit_err = bit_bad;
    if (sfr_acc && !i_acc_wr) begin
      nxt_rdata = read_byte;
      if (i_acc_bit) begin
        nxt_rdata = {7'h00, read_byte[i_acc_addr[2:0]]};
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 8'h00;
      bit_err_ff <= 1'b0;
    end else begin
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      bit_err_ff <= nxt_bit_err;
    end
  end

  assign o_acc_rvalid       = rvalid_ff;
  assign o_acc_rdata        = rdata_ff;
  assign o_acc_bit_err      = bit_err_ff;
  assign o_page_select      = entry_q[0];
  assign o_auto_page_enable = auto_en_ff;

endmodule

`default_nettype wire

// File: verification/sps_page_stack_checker.sv
/* Port assertions for sps_page_stack.
   Assumes a bind to that module, one clock and an async high reset. */
`timescale 1ns/1ns
`default_nettype none
module sps_page_stack_checker (
  input wire logic       i_mclk,
  input wire logic       i_rst,
  input wire logic       i_acc_valid,
  input wire logic       i_acc_direct,
  input wire logic       i_acc_bit,
  input wire logic       i_acc_wr,
  input wire logic [7:0] i_acc_addr,
  input wire logic [7:0] i_acc_wdata,
  input wire logic       o_ram_valid,
  input wire logic       o_acc_rvalid,
  input wire logic       o_per_valid,
  input wire logic       i_int_entry,
  input wire logic [7:0] i_int_page,
  input wire logic       i_int_return,
  input wire logic [7:0] o_page_select,
  input wire logic       o_auto_page_enable
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  logic rq, pw, en;
  assign rq = i_acc_valid && i_acc_direct && !i_acc_bit;
  assign pw = rq && i_acc_wr && i_acc_addr == 8'ha7;
  assign en = o_auto_page_enable;
  property p_ram;
    rq && i_acc_addr[7] |-> !o_ram_valid;
  endproperty
  a_ram: assert property (p_ram) else $error("sfr sent to ram");
  property p_fwd;
    rq && i_acc_addr == 8'hc5 |-> o_per_valid;
  endproperty
  a_fwd: assert property (p_fwd) else $error("no strobe");
  property p_rv;
    rq && !i_acc_wr && i_acc_addr[7] |=> o_acc_rvalid;
  endproperty
  a_rv: assert property (p_rv) else $error("no rvalid");
  property p_pgw;
    pw && !i_int_entry && !i_int_return |=> o_page_select == $past(i_acc_wdata);
  endproperty
  a_pgw: assert property (p_pgw) else $error("page write lost");
  property p_psh;
    i_int_entry && en |=> o_page_select == $past(i_int_page);
  endproperty
  a_psh: assert property (p_psh) else $error("no page switch");
  property p_pop;
    i_int_entry && en ##1 i_int_return && !i_int_entry && en
      |=> o_page_select == $past(o_page_select, 2);
  endproperty
  a_pop: assert property (p_pop) else $error("bad restore");
  property p_off;
    !en && !pw |=> $stable(o_page_select);
  endproperty
  a_off: assert property (p_off) else $error("page moved");
  property p_rst;
    $fell(i_rst) |-> en && o_page_select == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset");
endmodule
bind sps_page_stack sps_page_stack_checker u_sps_page_stack_checker (
  .i_mclk, .i_rst, .i_acc_valid, .i_acc_direct, .i_acc_bit, .i_acc_wr, .i_acc_addr,
  .i_acc_wdata, .o_ram_valid, .o_acc_rvalid, .o_per_valid, .i_int_entry, .i_int_page,
  .i_int_return, .o_page_select, .o_auto_page_enable
);
`default_nettype wire

// File: verification/sps_per_model.sv
/* Peripheral registers behind the page selector.
   Assumes strobes and read data share the request cycle. */
`timescale 1ns/1ns
`default_nettype none
module sps_per_model (
  input  wire logic       i_mclk,
  input  wire logic       i_valid,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_page,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata
);
  logic [7:0] mem [65536];
  logic [7:0] last = 8'h00;
  // Idle bus shows the inverse of the last value
  always_comb begin
    o_rdata = i_valid ? mem[{i_page, i_addr}] : ~last;
  end
  always @(posedge i_mclk) begin
    if (i_valid && i_wr) begin
      mem[{i_page, i_addr}] <= i_wdata;
    end
    if (i_valid) begin
      last <= o_rdata;
    end
  end
endmodule
`default_nettype wire

// File: verification/sps_page_stack_tb.sv
/* Self-checking bench for sps_page_stack.
   Assumes a 10 MHz clock; inputs change on the falling edge. */
`timescale 1ns/1ns
`default_nettype none
module sps_page_stack_tb;
  logic       i_mclk = 1'b0;
  logic       i_rst = 1'b1;
  logic       v = 1'b0, dr = 1'b0, bt = 1'b0, wr = 1'b0, ie = 1'b0, ir = 1'b0;
  logic [7:0] a = 8'h00, wd = 8'h00, ip = 8'h00;
  logic       rv, ram, pv, pw, en, rv_s;
  logic [7:0] rd, pa, pp, pd, prd, pg;
  int         bad_count = 0, n_compared = 0, cyc = 0;
  always #50 i_mclk = ~i_mclk;
  sps_page_stack u_sps_page_stack (
    .i_mclk, .i_rst, .i_acc_valid(v), .i_acc_direct(dr), .i_acc_bit(bt), .i_acc_wr(wr),
    .i_acc_addr(a), .i_acc_wdata(wd), .i_acc_wbit(1'b0), .o_acc_rvalid(rv), .o_acc_rdata(rd),
    .o_acc_bit_err(), .o_ram_valid(ram), .i_int_entry(ie), .i_int_page(ip),
    .i_int_return(ir), .o_per_valid(pv), .o_per_wr(pw), .o_per_bit(), .o_per_bit_pos(),
    .o_per_addr(pa), .o_per_page(pp), .o_per_wdata(pd), .o_per_wbit(), .i_per_rdata(prd),
    .o_page_select(pg), .o_auto_page_enable(en)
  );
  sps_per_model u_sps_per_model (
    .i_mclk, .i_valid(pv), .i_wr(pw), .i_addr(pa), .i_page(pp), .i_wdata(pd), .o_rdata(prd)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic d, b, w, input logic [7:0] ad, dt);
    v = 1'b1;
    dr = d;
    bt = b;
    wr = w;
    a = ad;
    wd = dt;
    @(negedge i_mclk);
    // Read strobe lasts one cycle; keep it before the idle cycle
    rv_s = rv;
    v = 1'b0;
    @(negedge i_mclk);
  endtask
  task automatic wrr(input logic [7:0] ad, dt);
    acc(1'b1, 1'b0, 1'b1, ad, dt);
  endtask
  task automatic rdc(input logic [7:0] ad, exp);
    acc(1'b1, 1'b0, 1'b0, ad, 8'h00);
    chk({7'h00, rv_s}, 8'h01);
    chk(rd, exp);
  endtask
  task automatic irq(input logic e, r, input logic [7:0] p);
    ie = e;
    ir = r;
    ip = p;
    @(negedge i_mclk);
    ie = 1'b0;
    ir = 1'b0;
    @(negedge i_mclk);
  endtask
  task automatic t_reset();
    chk(pg, 8'h00);
    wrr(8'ha7, 8'h10);
    rdc(8'hbc, 8'h01);
    $display("t_reset done");
  endtask
  task automatic t_paging();
    wrr(8'ha7, 8'h00);
    wrr(8'hc5, 8'h11);
    wrr(8'ha7, 8'h30);
    wrr(8'hc5, 8'h33);
    wrr(8'he0, 8'h5a);
    rdc(8'hc5, 8'h33);
    wrr(8'ha7, 8'h00);
    rdc(8'hc5, 8'h11);
    rdc(8'he0, 8'h5a);
    acc(1'b0, 1'b1, 1'b0, 8'he3, 8'h00);
    chk(rd, 8'h01);
    v = 1'b1;
    dr = 1'b0;
    bt = 1'b0;
    a = 8'hc5;
    #1 chk({7'h00, ram}, 8'h01);
    @(negedge i_mclk);
    v = 1'b0;
    chk({7'h00, rv}, 8'h00);
    @(negedge i_mclk);
    $display("t_paging done");
  endtask
  task automatic t_stack();
    logic [7:0] e [6] = '{8'h10, 8'h24, 8'h23, 8'h22, 8'h21, 8'h00};
    logic [7:0] p [5] = '{8'h24, 8'h23, 8'h22, 8'h21, 8'h21};
    wrr(8'ha7, 8'h10);
    for (int k = 1; k < 6; k++) begin
      irq(1'b1, 1'b0, 8'(8'h20 + k));
    end
    chk(pg, 8'h25);
    wrr(8'ha7, 8'h10);
    for (int k = 0; k < 6; k++) begin
      wrr(8'hbc, {1'b0, 3'(k), 4'h1});
      rdc(8'hd7, e[k]);
    end
    for (int k = 0; k < 5; k++) begin
      irq(1'b0, 1'b1, 8'h00);
      chk(pg, p[k]);
    end
    irq(1'b1, 1'b1, 8'h44);
    chk(pg, 8'h44);
    // Push directly followed by a pop
    ie = 1'b1;
    ip = 8'h66;
    @(negedge i_mclk);
    ie = 1'b0;
    ir = 1'b1;
    @(negedge i_mclk);
    ir = 1'b0;
    @(negedge i_mclk);
    chk(pg, 8'h44);
    $display("t_stack done");
  endtask
  task automatic t_disable();
    wrr(8'ha7, 8'h10);
    wrr(8'hbc, 8'h00);
    chk({7'h00, en}, 8'h00);
    irq(1'b1, 1'b0, 8'h55);
    chk(pg, 8'h10);
    irq(1'b0, 1'b1, 8'h00);
    chk(pg, 8'h10);
    // Reset in mid-run with auto paging off
    i_rst = 1'b1;
    @(negedge i_mclk);
    @(negedge i_mclk);
    i_rst = 1'b0;
    @(negedge i_mclk);
    chk({7'h00, en}, 8'h01);
    chk(pg, 8'h00);
    wrr(8'ha7, 8'h10);
    rdc(8'hbc, 8'h01);
    $display("t_disable done");
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      bad_count++;
      $display("[FAIL] %0t timeout", $time);
      print_verdict();
    end
  end
  initial begin
    repeat (5) @(negedge i_mclk);
    i_rst = 1'b0;
    t_reset();
    t_paging();
    t_stack();
    t_disable();
    print_verdict();
  end
endmodule
`default_nettype wire
